// file: stci_top.sv
// Module: register file, compare, event flags and interrupt of the always-on sleep timer.
`timescale 1ns/1ps
`default_nettype none

module stci_top (
  input  wire logic                    i_mclk,
  input  wire logic                    i_arst_n,
  input  wire stci_pkg::stci_apb_req_t i_apb,
  output var  logic [31:0]             o_prdata,
  output var  logic                    o_pready,
  output var  logic                    o_pslverr,
  input  wire logic                    i_tick,
  input  wire logic                    i_deep_rest_req,
  output var  logic                    o_deep_rest_timer_on,
  output var  logic                    o_deep_rest_timer_off,
  output var  logic                    o_rc_osc_keep_on,
  output var  logic                    o_crystal_osc_on,
  output var  stci_pkg::stci_evt_t     o_wake_event,
  output var  logic                    o_irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [31:0]         count;
  logic                step;
  logic                wrap;
  logic                timer_run_bit;
  logic [1:0]          run_pipe;
  logic [31:0]         cmp_a;
  logic [31:0]         cmp_b;
  logic [15:0]         hold_a;
  logic [15:0]         hold_b;
  logic [15:0]         cnt_low_hold;
  logic [15:0]         count_low_snapshot;
  logic [2:0]          event_flags;
  logic [2:0]          event_irq_mask;
  stci_pkg::stci_evt_t evt;
  logic                setup;
  logic                done;
  logic                wr_done;
  logic                rd_done;
  logic [2:0]          next_flags;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic hit(input logic [31:0] addr, input logic [31:0] reg_addr);
    hit = (addr == reg_addr);
  endfunction : hit

  function automatic logic mapped(input logic [31:0] addr);
    mapped = hit(addr, stci_pkg::ADDR_CLK_EN)   || hit(addr, stci_pkg::ADDR_RUN_CFG)  ||
             hit(addr, stci_pkg::ADDR_CNT_HIGH) || hit(addr, stci_pkg::ADDR_CNT_LOW)  ||
             hit(addr, stci_pkg::ADDR_CMPA_UP)  || hit(addr, stci_pkg::ADDR_CMPA_LO)  ||
             hit(addr, stci_pkg::ADDR_CMPB_UP)  || hit(addr, stci_pkg::ADDR_CMPB_LO)  ||
             hit(addr, stci_pkg::ADDR_FLAGS)    || hit(addr, stci_pkg::ADDR_MASK);
  endfunction : mapped

  assign setup   = i_apb.psel && !i_apb.penable;
  assign done    = i_apb.psel && i_apb.penable && o_pready;
  assign wr_done = done && i_apb.pwrite && !o_pslverr;
  assign rd_done = done && !i_apb.pwrite;

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  // The answer is prepared in the setup cycle so every bus output can come from a flip-flop.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= setup;
      o_pslverr <= setup && !mapped(i_apb.paddr);
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_prdata     <= 32'h0000_0000;
      cnt_low_hold <= 16'h0000;
    end else if (setup && !i_apb.pwrite) begin
      o_prdata     <= 32'h0000_0000;
      cnt_low_hold <= count[15:0];
      if (hit(i_apb.paddr, stci_pkg::ADDR_CLK_EN)) begin
        o_prdata[stci_pkg::RC_KEEP_POS] <= o_rc_osc_keep_on;
        o_prdata[stci_pkg::XTAL_ON_POS] <= o_crystal_osc_on;
      end
      if (hit(i_apb.paddr, stci_pkg::ADDR_RUN_CFG)) begin
        o_prdata[stci_pkg::RUN_BIT_POS] <= timer_run_bit;
      end
      if (hit(i_apb.paddr, stci_pkg::ADDR_CNT_HIGH)) begin
        o_prdata[15:0] <= count[31:16];
      end
      if (hit(i_apb.paddr, stci_pkg::ADDR_CNT_LOW)) begin
        o_prdata[15:0] <= count_low_snapshot;
      end
      if (hit(i_apb.paddr, stci_pkg::ADDR_CMPA_UP)) begin
        o_prdata[15:0] <= cmp_a[31:16];
      end
      if (hit(i_apb.paddr, stci_pkg::ADDR_CMPA_LO)) begin
        o_prdata[15:0] <= cmp_a[15:0];
      end
      if (hit(i_apb.paddr, stci_pkg::ADDR_CMPB_UP)) begin
        o_prdata[15:0] <= cmp_b[31:16];
      end
      if (hit(i_apb.paddr, stci_pkg::ADDR_CMPB_LO)) begin
        o_prdata[15:0] <= cmp_b[15:0];
      end
      if (hit(i_apb.paddr, stci_pkg::ADDR_FLAGS)) begin
        o_prdata[2:0] <= event_flags;
      end
      if (hit(i_apb.paddr, stci_pkg::ADDR_MASK)) begin
        o_prdata[2:0] <= event_irq_mask;
      end
    end
  end

  // ****************************************************************
  // Count read-out
  // ****************************************************************
  // The low half is taken when the high half is read, so the pair is coherent.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      count_low_snapshot <= 16'h0000;
    end else if (rd_done && hit(i_apb.paddr, stci_pkg::ADDR_CNT_HIGH)) begin
      count_low_snapshot <= cnt_low_hold;
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rc_osc_keep_on <= stci_pkg::CLK_EN_RESET[stci_pkg::RC_KEEP_POS];
      o_crystal_osc_on <= stci_pkg::CLK_EN_RESET[stci_pkg::XTAL_ON_POS];
      timer_run_bit    <= 1'b0;
      event_irq_mask   <= stci_pkg::EVT_RESET;
    end else if (wr_done) begin
      if (hit(i_apb.paddr, stci_pkg::ADDR_CLK_EN)) begin
        o_rc_osc_keep_on <= i_apb.pwdata[stci_pkg::RC_KEEP_POS];
        o_crystal_osc_on <= i_apb.pwdata[stci_pkg::XTAL_ON_POS];
      end
      if (hit(i_apb.paddr, stci_pkg::ADDR_RUN_CFG)) begin
        timer_run_bit <= i_apb.pwdata[stci_pkg::RUN_BIT_POS];
      end
      if (hit(i_apb.paddr, stci_pkg::ADDR_MASK)) begin
        event_irq_mask <= i_apb.pwdata[2:0];
      end
    end
  end

  // ****************************************************************
  // Compare values
  // ****************************************************************
  // Software is expected to stop the timer first; a live change can match early.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hold_a <= stci_pkg::CMP_HALF_RESET;
      hold_b <= stci_pkg::CMP_HALF_RESET;
      cmp_a  <= stci_pkg::CMP_RESET;
      cmp_b  <= stci_pkg::CMP_RESET;
    end else if (wr_done) begin
      if (hit(i_apb.paddr, stci_pkg::ADDR_CMPA_LO)) begin
        hold_a <= i_apb.pwdata[15:0];
      end
      if (hit(i_apb.paddr, stci_pkg::ADDR_CMPA_UP)) begin
        cmp_a <= {i_apb.pwdata[15:0], hold_a};
      end
      if (hit(i_apb.paddr, stci_pkg::ADDR_CMPB_LO)) begin
        hold_b <= i_apb.pwdata[15:0];
      end
      if (hit(i_apb.paddr, stci_pkg::ADDR_CMPB_UP)) begin
        cmp_b <= {i_apb.pwdata[15:0], hold_b};
      end
    end
  end

  // ****************************************************************
  // Counter and run synchroniser
  // ****************************************************************
  // The run bit passes two slow ticks before the counter sees it.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      run_pipe <= 2'h0;
    end else if (i_tick) begin
      run_pipe <= {run_pipe[0], timer_run_bit};
    end
  end

  stci_counter u_counter (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_tick   (i_tick),
    .i_run    (run_pipe[stci_pkg::RUN_SYNC_TICKS-1]),
    .o_count  (count),
    .o_step   (step),
    .o_wrap   (wrap)
  );

  // ****************************************************************
  // Events, flags and interrupt
  // ****************************************************************
  always_comb begin
    evt.cmpa   = step && (count == cmp_a);
    evt.cmpb   = step && (count == cmp_b);
    evt.wrap   = wrap;
    next_flags = event_flags;
    if (wr_done && hit(i_apb.paddr, stci_pkg::ADDR_FLAGS)) begin
      next_flags = next_flags & ~i_apb.pwdata[2:0];
    end
    next_flags = next_flags | evt;
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      event_flags  <= stci_pkg::EVT_RESET;
      o_wake_event <= stci_pkg::EVT_RESET;
      o_irq        <= 1'b0;
    end else begin
      event_flags  <= next_flags;
      o_wake_event <= evt;
      o_irq        <= |(event_flags & event_irq_mask);
    end
  end

  // ****************************************************************
  // Deep rest mode choice
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_deep_rest_timer_on  <= 1'b0;
      o_deep_rest_timer_off <= 1'b0;
    end else begin
      o_deep_rest_timer_on  <= i_deep_rest_req && o_rc_osc_keep_on;
      o_deep_rest_timer_off <= i_deep_rest_req && !o_rc_osc_keep_on;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  sequence s_read_high;
    setup && !i_apb.pwrite && hit(i_apb.paddr, stci_pkg::ADDR_CNT_HIGH) ##1 done;
  endsequence

  sequence s_write_done(logic [31:0] a);
    setup && i_apb.pwrite && hit(i_apb.paddr, a) ##1 done;
  endsequence

  a_high_read_snap: assert property (s_read_high |=> count_low_snapshot == $past(count[15:0], 2))
    else $error("Count low snapshot not coherent with high read.");
  a_cmpa_load: assert property (s_write_done(stci_pkg::ADDR_CMPA_UP) |=>
      cmp_a == {$past(i_apb.pwdata[15:0]), $past(hold_a)})
    else $error("Compare A not loaded from high write and hold.");
  a_cmpb_load: assert property (s_write_done(stci_pkg::ADDR_CMPB_UP) |=>
      cmp_b == {$past(i_apb.pwdata[15:0]), $past(hold_b)})
    else $error("Compare B not loaded from high write and hold.");
  a_cmpa_low_held: assert property (s_write_done(stci_pkg::ADDR_CMPA_LO) |=>
      $stable(cmp_a) && hold_a == $past(i_apb.pwdata[15:0]))
    else $error("Compare A low write changed the active value.");
  a_cmpa_flag_set: assert property (step && count == cmp_a |=> event_flags[1] && o_wake_event.cmpa)
    else $error("Compare A match did not set its flag.");
  a_wrap_flag_set: assert property (wrap |=> event_flags[0])
    else $error("Counter wrap did not set its flag.");
  a_flag_w1c: assert property (wr_done && hit(i_apb.paddr, stci_pkg::ADDR_FLAGS) && i_apb.pwdata[1]
      && !evt.cmpa |=> !event_flags[1])
    else $error("Write of one did not clear compare A flag.");
  a_irq_level: assert property (|(event_flags & event_irq_mask) |=> o_irq)
    else $error("Interrupt not raised for masked-in flag.");
  a_irq_quiet: assert property (!(|(event_flags & event_irq_mask)) |=> !o_irq)
    else $error("Interrupt raised with no masked-in flag.");
  a_step_needs_run: assert property (step |-> $past(run_pipe[1]) && $past(i_tick))
    else $error("Counter stepped while not running.");
  a_deep_choice: assert property (i_deep_rest_req |=>
      o_deep_rest_timer_on == $past(o_rc_osc_keep_on) && o_deep_rest_timer_off != $past(o_rc_osc_keep_on))
    else $error("Wrong deep rest mode chosen.");

endmodule : stci_top
`default_nettype wire

// file: stci_pkg.sv
// Package: register map, field layout, reset values and carrier types of the sleep timer compare block.
package stci_pkg;

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [31:0] ADDR_CLK_EN   = 32'h4000_0008;
  localparam logic [31:0] ADDR_RUN_CFG  = 32'h4000_600c;
  localparam logic [31:0] ADDR_CNT_HIGH = 32'h4000_6010;
  localparam logic [31:0] ADDR_CNT_LOW  = 32'h4000_6014;
  localparam logic [31:0] ADDR_CMPA_UP  = 32'h4000_6018;
  localparam logic [31:0] ADDR_CMPA_LO  = 32'h4000_601c;
  localparam logic [31:0] ADDR_CMPB_UP  = 32'h4000_6020;
  localparam logic [31:0] ADDR_CMPB_LO  = 32'h4000_6024;
  localparam logic [31:0] ADDR_FLAGS    = 32'h4000_a014;
  localparam logic [31:0] ADDR_MASK     = 32'h4000_a054;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int          RUN_BIT_POS      = 11;
  localparam int          RC_KEEP_POS      = 1;
  localparam int          XTAL_ON_POS      = 0;
  localparam logic [1:0]  CLK_EN_RESET     = 2'h2;
  localparam logic [15:0] CMP_HALF_RESET   = 16'hffff;
  localparam logic [31:0] CMP_RESET        = 32'hffff_ffff;
  localparam logic [31:0] CNT_MAX          = 32'hffff_ffff;
  localparam logic [2:0]  EVT_RESET        = 3'h0;
  localparam int          RUN_SYNC_TICKS   = 2;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } stci_apb_req_t;

  typedef struct packed {
    logic cmpb;
    logic cmpa;
    logic wrap;
  } stci_evt_t;

endpackage : stci_pkg

// file: stci_counter.sv
// Module: 32-bit up counter of the sleep timer, advanced by ticks of the selected slow clock.
`timescale 1ns/1ps
`default_nettype none

module stci_counter (
  input  wire logic        i_mclk,
  input  wire logic        i_arst_n,
  input  wire logic        i_tick,
  input  wire logic        i_run,
  output var  logic [31:0] o_count,
  output var  logic        o_step,
  output var  logic        o_wrap
);

  // ****************************************************************
  // Count
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_count <= 32'h0000_0000;
    end else if (i_tick && i_run) begin
      o_count <= o_count + 32'h0000_0001;
    end
  end

  // Step and wrap pulse in the same cycle the new count shows.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_step <= 1'b0;
      o_wrap <= 1'b0;
    end else begin
      o_step <= i_tick && i_run;
      o_wrap <= i_tick && i_run && (o_count == stci_pkg::CNT_MAX);
    end
  end

endmodule : stci_counter
`default_nettype wire

// file: sleep_timer_compare_irq_test.sv
// Testbench: register, compare, event flag, interrupt and deep rest checks of the sleep timer block.
`timescale 1ns/1ps
`default_nettype none

module sleep_timer_compare_irq_test;
  // ****************************************************************
  // Signals and design
  // ****************************************************************
  logic                    i_mclk;
  logic                    i_arst_n;
  stci_pkg::stci_apb_req_t apb;
  logic [31:0]             o_prdata;
  logic                    o_pready;
  logic                    o_pslverr;
  logic                    i_tick;
  logic                    i_deep_rest_req;
  logic                    o_deep_rest_timer_on;
  logic                    o_deep_rest_timer_off;
  logic                    o_rc_osc_keep_on;
  logic                    o_crystal_osc_on;
  stci_pkg::stci_evt_t     o_wake_event;
  logic                    o_irq;
  int                      errors;
  int                      checked;
  logic                    seen_a;
  logic                    seen_b;
  logic [31:0]             rd;

  stci_top dut (
    .i_mclk                (i_mclk),
    .i_arst_n              (i_arst_n),
    .i_apb                 (apb),
    .o_prdata              (o_prdata),
    .o_pready              (o_pready),
    .o_pslverr             (o_pslverr),
    .i_tick                (i_tick),
    .i_deep_rest_req       (i_deep_rest_req),
    .o_deep_rest_timer_on  (o_deep_rest_timer_on),
    .o_deep_rest_timer_off (o_deep_rest_timer_off),
    .o_rc_osc_keep_on      (o_rc_osc_keep_on),
    .o_crystal_osc_on      (o_crystal_osc_on),
    .o_wake_event          (o_wake_event),
    .o_irq                 (o_irq)
  );

  initial begin
    i_mclk = 1'b0;
  end

  always #2.5 i_mclk = ~i_mclk;

  // Wake pulses last one cycle, so they are latched here for the ticking loops.
  always @(posedge i_mclk) begin
    if (o_wake_event.cmpa === 1'b1) seen_a <= 1'b1;
    if (o_wake_event.cmpb === 1'b1) seen_b <= 1'b1;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  // One APB transfer; the request holds until pready is sampled high.
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] data, output logic err);
    int n;
    @(posedge i_mclk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge i_mclk);
    apb.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    data = o_prdata;
    err  = o_pslverr;
    if (n >= 50) chk(32'h0, 32'h1, "no pready");
    apb <= '0;
  endtask : xfer

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic exp_err);
    logic [31:0] data;
    logic        err;
    xfer(a, 1'b1, d, data, err);
    chk({31'h0, err}, {31'h0, exp_err}, "write error response");
  endtask : wr

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] data;
    logic        err;
    xfer(a, 1'b0, 32'h0, data, err);
    chk(data, exp, "read data");
    chk({31'h0, err}, {31'h0, exp_err}, "read error response");
  endtask : rdc

  // Ticks are spaced so that a wake pulse lands before the next tick.
  task automatic tick_until(ref logic seen, input int limit);
    int n;
    n = 0;
    while (seen !== 1'b1 && n < limit) begin
      @(posedge i_mclk);
      i_tick <= 1'b1;
      @(posedge i_mclk);
      i_tick <= 1'b0;
      repeat (6) @(posedge i_mclk);
      n++;
    end
    chk({31'h0, seen}, 32'h1, "wake pulse never came");
  endtask : tick_until

  task automatic rest_pulse(input logic exp_on);
    @(posedge i_mclk);
    i_deep_rest_req <= 1'b1;
    @(posedge i_mclk);
    i_deep_rest_req <= 1'b0;
    #1;
    chk({31'h0, o_deep_rest_timer_on}, {31'h0, exp_on}, "timer-on rest pulse");
    chk({31'h0, o_deep_rest_timer_off}, {31'h0, ~exp_on}, "timer-off rest pulse");
  endtask : rest_pulse

  task automatic test_done;
    $display("checks made %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (20000) @(posedge i_mclk);
    errors++;
    test_done();
  end

  initial begin
    errors = 0;
    checked = 0;
    seen_a = 1'b0;
    seen_b = 1'b0;
    apb = '0;
    i_tick = 1'b0;
    i_deep_rest_req = 1'b0;
    i_arst_n = 1'b0;
    repeat (10) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    chk({31'h0, o_rc_osc_keep_on}, 32'h1, "rc keep at reset");
    rdc(stci_pkg::ADDR_CLK_EN, 32'h2, 1'b0);
    rdc(stci_pkg::ADDR_CMPA_UP, 32'hffff, 1'b0);
    rdc(stci_pkg::ADDR_CMPA_LO, 32'hffff, 1'b0);
    rdc(stci_pkg::ADDR_CMPB_UP, 32'hffff, 1'b0);
    rdc(stci_pkg::ADDR_CMPB_LO, 32'hffff, 1'b0);
    rdc(stci_pkg::ADDR_FLAGS, 32'h0, 1'b0);
    rdc(stci_pkg::ADDR_MASK, 32'h0, 1'b0);
    rdc(32'h4000_6028, 32'h0, 1'b1);
    wr(32'h4000_a000, 32'h7, 1'b1);
    $display("reset and map test done");
    wr(stci_pkg::ADDR_CMPA_LO, 32'h5, 1'b0);
    rdc(stci_pkg::ADDR_CMPA_LO, 32'hffff, 1'b0);
    wr(stci_pkg::ADDR_CMPA_UP, 32'h0, 1'b0);
    rdc(stci_pkg::ADDR_CMPA_LO, 32'h5, 1'b0);
    rdc(stci_pkg::ADDR_CMPA_UP, 32'h0, 1'b0);
    wr(stci_pkg::ADDR_CMPB_LO, 32'h8, 1'b0);
    rdc(stci_pkg::ADDR_CMPB_LO, 32'hffff, 1'b0);
    wr(stci_pkg::ADDR_CMPB_UP, 32'h0, 1'b0);
    rdc(stci_pkg::ADDR_CMPB_LO, 32'h8, 1'b0);
    rdc(stci_pkg::ADDR_CMPB_UP, 32'h0, 1'b0);
    $display("compare load test done");
    wr(stci_pkg::ADDR_RUN_CFG, 32'h800, 1'b0);
    tick_until(seen_a, 12);
    rdc(stci_pkg::ADDR_CNT_HIGH, 32'h0, 1'b0);
    rdc(stci_pkg::ADDR_CNT_LOW, 32'h5, 1'b0);
    rdc(stci_pkg::ADDR_FLAGS, 32'h2, 1'b0);
    chk({31'h0, o_irq}, 32'h0, "irq while masked");
    wr(stci_pkg::ADDR_MASK, 32'h6, 1'b0);
    repeat (2) @(posedge i_mclk);
    chk({31'h0, o_irq}, 32'h1, "irq with unmasked flag");
    tick_until(seen_b, 8);
    rdc(stci_pkg::ADDR_CNT_HIGH, 32'h0, 1'b0);
    rdc(stci_pkg::ADDR_CNT_LOW, 32'h8, 1'b0);
    rdc(stci_pkg::ADDR_FLAGS, 32'h6, 1'b0);
    wr(stci_pkg::ADDR_FLAGS, 32'h0, 1'b0);
    rdc(stci_pkg::ADDR_FLAGS, 32'h6, 1'b0);
    wr(stci_pkg::ADDR_FLAGS, 32'h2, 1'b0);
    rdc(stci_pkg::ADDR_FLAGS, 32'h4, 1'b0);
    wr(stci_pkg::ADDR_MASK, 32'h2, 1'b0);
    rdc(stci_pkg::ADDR_MASK, 32'h2, 1'b0);
    repeat (2) @(posedge i_mclk);
    chk({31'h0, o_irq}, 32'h0, "irq with flag masked");
    wr(stci_pkg::ADDR_FLAGS, 32'h4, 1'b0);
    rdc(stci_pkg::ADDR_FLAGS, 32'h0, 1'b0);
    $display("compare event and interrupt test done");
    rest_pulse(1'b1);
    wr(stci_pkg::ADDR_CLK_EN, 32'h1, 1'b0);
    #1;
    chk({30'h0, o_rc_osc_keep_on, o_crystal_osc_on}, 32'h1, "clock enable outputs");
    rdc(stci_pkg::ADDR_CLK_EN, 32'h1, 1'b0);
    rest_pulse(1'b0);
    wr(stci_pkg::ADDR_CLK_EN, 32'h3, 1'b0);
    #1;
    chk({30'h0, o_rc_osc_keep_on, o_crystal_osc_on}, 32'h3, "clock enable outputs");
    rest_pulse(1'b1);
    $display("clock enable and deep rest test done");
    test_done();
  end
endmodule : sleep_timer_compare_irq_test

`default_nettype wire
